// >>> design/cdd_map.svh
/*
  Register offsets, field positions, reset values and fixed figures of the
  cascaded channel divider with duty-cycle correction.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef CDD_MAP_SVH
`define CDD_MAP_SVH

// Register offsets on the plain register port.
`define CDD_ADDR_W          8
`define CDD_OFF_STAGE1      8'h00
`define CDD_OFF_STAGE2      8'h04
`define CDD_OFF_BYPASS      8'h08
`define CDD_OFF_DCC         8'h0c
`define CDD_OFF_VCODIV      8'h10
`define CDD_OFF_STATUS      8'h14

// Divide field layout: low-cycle count above, high-cycle count below.
`define CDD_FLD_LOW_HI      7
`define CDD_FLD_LOW_LO      4
`define CDD_FLD_HIGH_HI     3
`define CDD_FLD_HIGH_LO     0

// Bypass, correction and pre-divider fields.
`define CDD_BIT_BYPASS1     0
`define CDD_BIT_BYPASS2     1
`define CDD_BIT_DCC_DISABLE 0
`define CDD_FLD_VCO_HI      2
`define CDD_FLD_VCO_LO      0
`define CDD_BIT_VCO_USE     3

// Status fields.
`define CDD_FLD_RATIO_HI    10
`define CDD_FLD_RATIO_LO    0
`define CDD_BIT_BAD_STAGE1  12
`define CDD_BIT_BAD_STAGE2  13
`define CDD_BIT_BAD_BYPASS  14
`define CDD_BIT_BAD_ORDER   15
`define CDD_BIT_DCC_ACTIVE  16
`define CDD_BIT_OUT_LEVEL   20

// Reset values.
`define CDD_RST_STAGE       8'h00
`define CDD_RST_BYPASS      2'h3
`define CDD_RST_DCC_DISABLE 1'h0
`define CDD_RST_VCO_RATIO   3'h2
`define CDD_RST_VCO_USE     1'h0

// Smallest pre-divide ratio; anything below passes the clock straight on.
`define CDD_VCO_MIN         3'h2

`endif

// >>> design/cdd_pkg.sv
/*
  Types of the cascaded channel divider: stage state, top-level state and
  the divide-stage phase enumeration.
  Assumes cdd_map.svh is on the include path.
*/
`include "cdd_map.svh"

package cdd_pkg;

  typedef enum logic [0:0] {
    CDD_LOW  = 1'b0,
    CDD_HIGH = 1'b1
  } cdd_phase_t;

  typedef struct packed {
    logic       prevIn;
    cdd_phase_t phase;
    logic [3:0] count;
    logic       primed;
    logic       extend;
    logic       outLevel;
  } cdd_stage_state_t;

  localparam cdd_stage_state_t CDD_STAGE_RST = '{
    prevIn:   1'b0,
    phase:    CDD_LOW,
    count:    4'h0,
    primed:   1'b1,
    extend:   1'b0,
    outLevel: 1'b0
  };

  typedef struct packed {
    logic        syncA;
    logic        syncB;
    logic [7:0]  stage1;
    logic [7:0]  stage2;
    logic [1:0]  bypass;
    logic        dccDisable;
    logic [2:0]  vcoRatio;
    logic        vcoUse;
    logic [31:0] rdData;
    logic        outLevel;
  } cdd_top_state_t;

endpackage

// >>> design/cdd_stage_if.sv
/*
  Carrier between the channel divider top and one divide stage: the input
  clock level, the stage settings and the divided output level.
  Assumes both ends run on ref_clk.
*/
interface cdd_stage_if;
  logic       clkLevel;
  logic [3:0] highCnt;
  logic [3:0] lowCnt;
  logic       bypass;
  logic       dccEnable;
  logic       outLevel;

  modport stage (
    input  clkLevel,
    input  highCnt,
    input  lowCnt,
    input  bypass,
    input  dccEnable,
    output outLevel
  );

  modport ctrl (
    output clkLevel,
    output highCnt,
    output lowCnt,
    output bypass,
    output dccEnable,
    input  outLevel
  );
endinterface

// >>> design/cdd_stage.sv
/*
  One divide stage: counts rising edges of its input level, drives the high
  phase then the low phase, and with correction on stretches the high phase
  of an odd ratio set one low cycle longer to the next falling input edge.
  Assumes the input level is already synchronous to ref_clk.
*/
module cdd_stage
  import cdd_pkg::*;
(
  // Clock and reset.
  input  wire logic  ref_clk,
  input  wire logic  rst_n,
  // Stage link.
  cdd_stage_if.stage link
);

  cdd_stage_state_t s;
  cdd_stage_state_t next_s;

  logic rise;
  logic fall;
  logic oddMatched;

  always_comb
  begin
    next_s = s;
    rise = link.clkLevel & ~s.prevIn;
    fall = ~link.clkLevel & s.prevIn;
    // Half a cycle of stretch only balances an odd ratio set one low cycle longer.
    oddMatched = ({1'b0, link.lowCnt} == 5'(link.highCnt) + 5'h01);
    next_s.prevIn = link.clkLevel;
    if (link.bypass)
    begin
      next_s.outLevel = link.clkLevel;
      next_s.phase = CDD_LOW;
      next_s.count = 4'h0;
      next_s.primed = 1'b1;
      next_s.extend = 1'b0;
    end
    else
    begin
      if (fall && s.extend)
      begin
        next_s.outLevel = 1'b0;
        next_s.extend = 1'b0;
      end
      if (rise)
      begin
        unique case (s.phase)
          CDD_HIGH:
          begin
            // A count already past a shortened limit ends the phase at once instead of wrapping.
            if (s.count >= link.highCnt)
            begin
              next_s.phase = CDD_LOW;
              next_s.count = 4'h0;
              if (link.dccEnable && oddMatched)
              begin
                next_s.extend = 1'b1;
              end
              else
              begin
                next_s.outLevel = 1'b0;
              end
            end
            else
            begin
              next_s.count = 4'(s.count + 4'h1);
            end
          end
          CDD_LOW:
          begin
            if (s.primed || s.count >= link.lowCnt)
            begin
              next_s.phase = CDD_HIGH;
              next_s.count = 4'h0;
              next_s.primed = 1'b0;
              next_s.extend = 1'b0;
              next_s.outLevel = 1'b1;
            end
            else
            begin
              next_s.count = 4'(s.count + 4'h1);
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= CDD_STAGE_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign link.outLevel = s.outLevel;

endmodule

// >>> design/cdd_channel_divider.sv
/*
  Channel divider with duty-cycle correction: optional pre-divider, then two
  cascaded 2 to 32 stages, with settings and status on a plain register port.
  Assumes distClkIn is asynchronous to ref_clk and well below its rate.
*/
// Behaviour
// - No correction, pre-divider: fixed or high-count duty.
// - No correction, no pre-divider: pass or high-count.
// - Correction with 50% input gives 50%; the code drops the correction in both stages, but not in the pre-divider, when any bad-settings status flag is set.
// - Correction stretches odd high phase by input; the code does so only when the low field is the high field plus one.
// - Fields hold cycle count minus one.
// - Channel ratio is product of stage ratios.
// - Correction on at reset; one disable bit.
`include "cdd_map.svh"

module cdd_channel_divider
  import cdd_pkg::*;
(
  // Clock and reset.
  input  wire  logic                    ref_clk,
  input  wire  logic                    rst_n,
  // Register port.
  input  wire  logic [`CDD_ADDR_W-1:0]  regAddr,
  input  wire  logic [31:0]             regWrData,
  input  wire  logic                    regWr,
  input  wire  logic                    regRd,
  output logic       [31:0]             regRdData,
  // Clock path.
  input  wire  logic                    distClkIn,
  output logic                          divClkOut
);

  cdd_top_state_t s;
  cdd_top_state_t next_s;

  cdd_stage_if preLink ();
  cdd_stage_if st1Link ();
  cdd_stage_if st2Link ();

  // A stage ratio as seen by the channel: bypass counts as one.
  function automatic logic [5:0] stageRatio(input logic [7:0] fld, input logic byp);
    logic [5:0] r;
    r = 6'(fld[`CDD_FLD_HIGH_HI:`CDD_FLD_HIGH_LO]) + 6'(fld[`CDD_FLD_LOW_HI:`CDD_FLD_LOW_LO]) + 6'h02;
    return byp ? 6'h01 : r;
  endfunction

  // Settings that break the correction for one active stage.
  function automatic logic stageBad(input logic [7:0] fld, input logic byp);
    logic [3:0] hi;
    logic [3:0] lo;
    hi = fld[`CDD_FLD_HIGH_HI:`CDD_FLD_HIGH_LO];
    lo = fld[`CDD_FLD_LOW_HI:`CDD_FLD_LOW_LO];
    if (byp)
    begin
      return 1'b0;
    end
    else if (hi[0] == lo[0])
    begin
      return lo != hi;
    end
    else
    begin
      return {1'b0, lo} != 5'(hi) + 5'h01;
    end
  endfunction

  logic [5:0]  ratio1;
  logic [5:0]  ratio2;
  logic [10:0] chanRatio;
  logic        badStage1;
  logic        badStage2;
  logic        badBypass;
  logic        badOrder;
  logic        dccOn;
  logic        dccEffective;
  logic        preActive;
  logic [2:0]  preHigh;
  logic [2:0]  preLow;
  logic [31:0] statusWord;

  always_comb
  begin
    ratio1 = stageRatio(s.stage1, s.bypass[`CDD_BIT_BYPASS1]);
    ratio2 = stageRatio(s.stage2, s.bypass[`CDD_BIT_BYPASS2]);
    chanRatio = 11'(ratio1) * 11'(ratio2);
    badStage1 = stageBad(s.stage1, s.bypass[`CDD_BIT_BYPASS1]);
    badStage2 = stageBad(s.stage2, s.bypass[`CDD_BIT_BYPASS2]);
    badBypass = s.bypass[`CDD_BIT_BYPASS1] & ~s.bypass[`CDD_BIT_BYPASS2];
    badOrder = ~s.bypass[`CDD_BIT_BYPASS1] & ~s.bypass[`CDD_BIT_BYPASS2]
             & ~ratio1[0] & ratio2[0];
    dccOn = ~s.dccDisable;
    // Violated settings lose the correction rather than give an odd duty.
    dccEffective = dccOn & ~(badStage1 | badStage2 | badBypass | badOrder);
    preActive = s.vcoUse && (s.vcoRatio >= `CDD_VCO_MIN);
    // The pre-divider keeps the shorter half high: 3 gives 1 of 3, 5 gives 2 of 5.
    preHigh = 3'(s.vcoRatio >> 1);
    preLow = 3'(s.vcoRatio - preHigh);
  end

  always_comb
  begin
    statusWord = 32'h0000_0000;
    statusWord[`CDD_FLD_RATIO_HI:`CDD_FLD_RATIO_LO] = chanRatio;
    statusWord[`CDD_BIT_BAD_STAGE1] = badStage1;
    statusWord[`CDD_BIT_BAD_STAGE2] = badStage2;
    statusWord[`CDD_BIT_BAD_BYPASS] = badBypass;
    statusWord[`CDD_BIT_BAD_ORDER] = badOrder;
    statusWord[`CDD_BIT_DCC_ACTIVE] = dccEffective;
    statusWord[`CDD_BIT_OUT_LEVEL] = s.outLevel;
  end

  // Stage wiring: pre-divider, first stage, second stage in cascade.
  assign preLink.clkLevel = s.syncB;
  assign preLink.highCnt = 4'(preHigh - 3'h1);
  assign preLink.lowCnt = 4'(preLow - 3'h1);
  assign preLink.bypass = ~preActive;
  assign preLink.dccEnable = dccOn;

  assign st1Link.clkLevel = preLink.outLevel;
  assign st1Link.highCnt = s.stage1[`CDD_FLD_HIGH_HI:`CDD_FLD_HIGH_LO];
  assign st1Link.lowCnt = s.stage1[`CDD_FLD_LOW_HI:`CDD_FLD_LOW_LO];
  assign st1Link.bypass = s.bypass[`CDD_BIT_BYPASS1];
  assign st1Link.dccEnable = dccEffective;

  assign st2Link.clkLevel = st1Link.outLevel;
  assign st2Link.highCnt = s.stage2[`CDD_FLD_HIGH_HI:`CDD_FLD_HIGH_LO];
  assign st2Link.lowCnt = s.stage2[`CDD_FLD_LOW_HI:`CDD_FLD_LOW_LO];
  assign st2Link.bypass = s.bypass[`CDD_BIT_BYPASS2];
  assign st2Link.dccEnable = dccEffective;

  cdd_stage u_pre (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .link    (preLink)
  );

  cdd_stage u_st1 (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .link    (st1Link)
  );

  cdd_stage u_st2 (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .link    (st2Link)
  );

  always_comb
  begin
    next_s = s;
    // Only the second flop of the pin synchroniser feeds any logic.
    next_s.syncA = distClkIn;
    next_s.syncB = s.syncA;
    // The last active stage sets the duty; a bypassed stage passes its input on.
    next_s.outLevel = st2Link.outLevel;
    next_s.rdData = 32'h0000_0000;
    if (regWr)
    begin
      unique case (regAddr)
        `CDD_OFF_STAGE1: next_s.stage1 = regWrData[7:0];
        `CDD_OFF_STAGE2: next_s.stage2 = regWrData[7:0];
        `CDD_OFF_BYPASS:
        begin
          next_s.bypass[`CDD_BIT_BYPASS1] = regWrData[`CDD_BIT_BYPASS1];
          next_s.bypass[`CDD_BIT_BYPASS2] = regWrData[`CDD_BIT_BYPASS2];
        end
        `CDD_OFF_DCC: next_s.dccDisable = regWrData[`CDD_BIT_DCC_DISABLE];
        `CDD_OFF_VCODIV:
        begin
          next_s.vcoRatio = regWrData[`CDD_FLD_VCO_HI:`CDD_FLD_VCO_LO];
          next_s.vcoUse = regWrData[`CDD_BIT_VCO_USE];
        end
        default: next_s.rdData = 32'h0000_0000;
      endcase
    end
    if (regRd)
    begin
      unique case (regAddr)
        `CDD_OFF_STAGE1: next_s.rdData = {24'h00_0000, s.stage1};
        `CDD_OFF_STAGE2: next_s.rdData = {24'h00_0000, s.stage2};
        `CDD_OFF_BYPASS: next_s.rdData = {30'h0000_0000, s.bypass};
        `CDD_OFF_DCC:    next_s.rdData = {31'h0000_0000, s.dccDisable};
        `CDD_OFF_VCODIV: next_s.rdData = {28'h000_0000, s.vcoUse, s.vcoRatio};
        `CDD_OFF_STATUS: next_s.rdData = statusWord;
        default:         next_s.rdData = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '{
        syncA:      1'b0,
        syncB:      1'b0,
        stage1:     `CDD_RST_STAGE,
        stage2:     `CDD_RST_STAGE,
        bypass:     `CDD_RST_BYPASS,
        dccDisable: `CDD_RST_DCC_DISABLE,
        vcoRatio:   `CDD_RST_VCO_RATIO,
        vcoUse:     `CDD_RST_VCO_USE,
        rdData:     32'h0000_0000,
        outLevel:   1'b0
      };
    end
    else
    begin
      s <= next_s;
    end
  end

  assign regRdData = s.rdData;
  assign divClkOut = s.outLevel;

endmodule

// >>> tb/cdd_channel_divider_properties.sv
/* Port checker of the channel divider: readback, status, pass-through, reset level.
   Assumes it is bound to cdd_channel_divider and runs on ref_clk alone. */
`include "cdd_map.svh"
module cdd_channel_divider_chk
  import cdd_pkg::*;
(
  // Clock, reset and register port.
  input wire logic                   ref_clk,
  input wire logic                   rst_n,
  input wire logic [`CDD_ADDR_W-1:0] regAddr,
  input wire logic [31:0]            regWrData,
  input wire logic                   regWr,
  input wire logic                   regRd,
  input wire logic [31:0]            regRdData,
  // Clock path.
  input wire logic                   distClkIn,
  input wire logic                   divClkOut
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  st1, st2;
  logic [1:0]  byp;
  logic [3:0]  vco;
  logic        duty_correction_disable, pass, rdSt;
  logic [10:0] d1, d2, ratio;
  logic [31:0] expRd;
  // Shadow settings, so that no expectation is read back from the design.
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      st1    <= `CDD_RST_STAGE;
      st2    <= `CDD_RST_STAGE;
      byp    <= `CDD_RST_BYPASS;
      duty_correction_disable <= `CDD_RST_DCC_DISABLE;
      vco    <= {`CDD_RST_VCO_USE, `CDD_RST_VCO_RATIO};
    end
    else if (regWr)
    begin
      if (regAddr == `CDD_OFF_STAGE1) st1 <= regWrData[7:0];
      if (regAddr == `CDD_OFF_STAGE2) st2 <= regWrData[7:0];
      if (regAddr == `CDD_OFF_BYPASS) byp <= regWrData[1:0];
      if (regAddr == `CDD_OFF_DCC) duty_correction_disable <= regWrData[0];
      if (regAddr == `CDD_OFF_VCODIV) vco <= regWrData[3:0];
    end
  always_comb
  begin
    d1 = byp[0] ? 11'h1 : 11'(st1[7:4]) + 11'(st1[3:0]) + 11'h2;
    d2 = byp[1] ? 11'h1 : 11'(st2[7:4]) + 11'(st2[3:0]) + 11'h2;
    ratio = d1 * d2;
    pass = (byp == 2'h3) && (!vco[3] || vco[2:0] < `CDD_VCO_MIN);
    rdSt = regRd && (regAddr == `CDD_OFF_STATUS);
    case (regAddr)
      `CDD_OFF_STAGE1: expRd = {24'h0, st1};
      `CDD_OFF_STAGE2: expRd = {24'h0, st2};
      `CDD_OFF_BYPASS: expRd = {30'h0, byp};
      `CDD_OFF_DCC:    expRd = {31'h0, duty_correction_disable};
      `CDD_OFF_VCODIV: expRd = {28'h0, vco};
      default:         expRd = 32'h0;
    endcase
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  a_read_idle_zero: assert property (!$past(regRd) |-> regRdData == 32'h0)
    else $error("read data not zero outside a read slot");
  a_reg_readback: assert property ($past(regRd && !rdSt) |-> regRdData == $past(expRd))
    else $error("register read data differs from last write");
  a_status_ratio: assert property ($past(rdSt) |-> regRdData[10:0] == $past(ratio))
    else $error("status ratio wrong");
  a_bypass_order: assert property ($past(rdSt) |-> regRdData[14] == $past(byp == 2'h1))
    else $error("single bypass flag wrong");
  a_even_order: assert property ($past(rdSt && byp == 2'h0) |-> regRdData[15] == $past(!d1[0] && d2[0]))
    else $error("even order flag wrong");
  a_status_level: assert property ($past(rdSt) |-> regRdData[20] == $past(divClkOut))
    else $error("status output level differs from output pin");
  a_out_reset_low: assert property ($rose(rst_n) |-> !divClkOut)
    else $error("output high right after reset");
  a_pass_rise: assert property ($rose(distClkIn) && pass |-> ##[2:8] (divClkOut || !pass))
    else $error("bypassed output missed a rising input");
  a_pass_fall: assert property ($fell(distClkIn) && pass |-> ##[2:8] (!divClkOut || !pass))
    else $error("bypassed output missed a falling input");
  c_divided: cover property ($rose(divClkOut) && !pass);
  c_status: cover property ($past(rdSt) && regRdData[14]);
  c_dcc_off: cover property (regWr && regAddr == `CDD_OFF_DCC && regWrData[0]);
endmodule
bind cdd_channel_divider cdd_channel_divider_chk chk (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .distClkIn(distClkIn),
  .divClkOut(divClkOut));

// >>> tb/cdd_out_monitor.sv
/* Output monitor: measures high and low phase lengths of the divided clock.
   Assumes the divided clock is a level synchronous to ref_clk. */
module cdd_out_monitor (
  // Clock and reset.
  input wire logic   ref_clk,
  input wire logic   rst_n,
  // Divided clock and its last phase lengths in ref_clk cycles.
  input wire logic   clkIn,
  output logic [15:0] highLen,
  output logic [15:0] lowLen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] run;
  logic        last;
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      run     <= 16'h0;
      last    <= 1'b0;
      highLen <= 16'h0;
      lowLen  <= 16'h0;
    end
    else
    begin
      last <= clkIn;
      run  <= (clkIn != last) ? 16'h1 : run + 16'h1;
      if (clkIn && !last) lowLen <= run;
      if (!clkIn && last) highLen <= run;
    end
endmodule

// >>> tb/cdd_channel_divider_test.sv
/* Self-checking bench of the channel divider: duty table, status, reset defaults.
   Assumes the checker is bound and the input clock period is 10 ref_clk cycles. */
`include "cdd_map.svh"
module cdd_channel_divider_test
  import cdd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0]  s1, s2;
    logic [1:0]  byp;
    logic        off;
    logic [3:0]  vco, inHi;
    logic [15:0] hi, lo;
  } cdd_row_t;
  // Input high time 6 of 10 keeps the odd corrected cases off 50%, as the stretch lasts the input high time.
  localparam cdd_row_t ROWS [13] = '{
    '{8'h00, 8'h00, 2'h3, 1'b0, 4'h0, 4'h6, 16'h6, 16'h4},
    '{8'h11, 8'h00, 2'h2, 1'b0, 4'h0, 4'h6, 16'h14, 16'h14},
    '{8'h21, 8'h00, 2'h2, 1'b1, 4'h0, 4'h6, 16'h14, 16'h1e},
    '{8'h21, 8'h00, 2'h2, 1'b0, 4'h0, 4'h6, 16'h1a, 16'h18},
    '{8'h10, 8'h11, 2'h0, 1'b0, 4'h0, 4'h6, 16'h3c, 16'h3c},
    '{8'h00, 8'h00, 2'h3, 1'b1, 4'hb, 4'h6, 16'ha, 16'h14},
    '{8'h00, 8'h00, 2'h3, 1'b0, 4'hb, 4'h6, 16'h10, 16'he},
    '{8'h00, 8'h00, 2'h3, 1'b1, 4'hd, 4'h6, 16'h14, 16'h1e},
    '{8'h00, 8'h00, 2'h3, 1'b0, 4'hd, 4'h6, 16'h1a, 16'h18},
    '{8'h00, 8'h00, 2'h3, 1'b1, 4'hc, 4'h6, 16'h14, 16'h14},
    '{8'h00, 8'h21, 2'h1, 1'b0, 4'h0, 4'h6, 16'h14, 16'h1e},
    '{8'h10, 8'h00, 2'h2, 1'b0, 4'hb, 4'h5, 16'h2d, 16'h2d},
    '{8'h11, 8'h21, 2'h0, 1'b0, 4'h0, 4'h6, 16'h50, 16'h78}};
  logic        ref_clk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0, distClkIn = 1'b0;
  logic [7:0]  regAddr = 8'h0;
  logic [31:0] regWrData = 32'h0, regRdData;
  logic        divClkOut;
  logic [15:0] highLen, lowLen;
  logic [3:0]  inHigh = 4'h6, ph = 4'h0;
  int          failCount = 0, checksDone = 0;
  cdd_channel_divider uut (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .distClkIn(distClkIn), .divClkOut(divClkOut));
  cdd_out_monitor drv (.ref_clk(ref_clk), .rst_n(rst_n), .clkIn(divClkOut), .highLen(highLen), .lowLen(lowLen));
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    ph        <= (ph == 4'h9) ? 4'h0 : ph + 4'h1;
    distClkIn <= (ph < inHigh);
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      failCount++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge ref_clk);
    regWr     <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge ref_clk);
    regRd   <= 1'b0;
    @(negedge ref_clk);
    check(regRdData & m, e);
  endtask
  task automatic endSim;
    $display("Checks %0d, mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    failCount++;
    endSim();
  end
  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (ROWS[i])
    begin
      inHigh <= ROWS[i].inHi;
      wr(`CDD_OFF_STAGE1, {24'h0, ROWS[i].s1});
      wr(`CDD_OFF_STAGE2, {24'h0, ROWS[i].s2});
      wr(`CDD_OFF_BYPASS, {30'h0, ROWS[i].byp});
      wr(`CDD_OFF_DCC, {31'h0, ROWS[i].off});
      wr(`CDD_OFF_VCODIV, {28'h0, ROWS[i].vco});
      repeat (4 * (ROWS[i].hi + ROWS[i].lo)) @(posedge ref_clk);
      check({16'h0, highLen}, {16'h0, ROWS[i].hi});
      check({16'h0, lowLen}, {16'h0, ROWS[i].lo});
    end
    rdchk(`CDD_OFF_STATUS, 32'h0000ffff, 32'h00008014);
    wr(`CDD_OFF_BYPASS, 32'h1);
    rdchk(`CDD_OFF_STATUS, 32'h00007fff, 32'h00004005);
    wr(`CDD_OFF_STAGE1, 32'hffffffff);
    wr(`CDD_OFF_STAGE2, 32'h000000ff);
    wr(`CDD_OFF_BYPASS, 32'h0);
    rdchk(`CDD_OFF_STATUS, 32'h0001ffff, 32'h00010400);
    wr(`CDD_OFF_STAGE2, 32'h00000012);
    rdchk(`CDD_OFF_STATUS, 32'h0001ffff, 32'h0000a0a0);
    rdchk(`CDD_OFF_STAGE1, 32'hffffffff, 32'h000000ff);
    wr(8'h18, 32'hffffffff);
    rdchk(8'h18, 32'hffffffff, 32'h0);
    wr(`CDD_OFF_DCC, 32'h1);
    rdchk(`CDD_OFF_DCC, 32'hffffffff, 32'h1);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdchk(`CDD_OFF_STAGE1, 32'hffffffff, 32'h0);
    rdchk(`CDD_OFF_BYPASS, 32'hffffffff, 32'h3);
    rdchk(`CDD_OFF_DCC, 32'hffffffff, 32'h0);
    rdchk(`CDD_OFF_VCODIV, 32'hffffffff, 32'h2);
    endSim();
  end
endmodule
